// File: hw/dram_host.sv
// How it works
// - wait 200 us after reset, then eight row cycles before any access
// - idle over 8 ms forces an eight-cycle wake burst before access
// - row field on row strobe fall, column field on later column fall
// - write strobe stays high at least read setup before column fall
// - strobes meet pulse widths; write strobe high through read
// - row strobe stays high a full precharge before next cycle
// - early write: write strobe low before column fall, data driven
// - page mode keeps the row open, each column fall a new column
// - column precharge between page cycles; reads and writes mix
// - row strobe rises with or after column, except before hidden refresh; page time is bounded
// - all 512 rows refreshed within the retention period
// - one row refresh about every 15.6 us, distributed
// - row-only refresh drives the row from our own counter
// - hidden refresh holds column low while row cycles high and low
// - test cycles only after eight column before row cycles
`timescale 1ns/1ps
`default_nettype none

module dram_host
  import dram_ctrl_pkg::*;
#(
  parameter int PWR_WAIT_CYC = POWER_WAIT_CYC,
  parameter int IDLE_CYC = IDLE_LIMIT_CYC,
  parameter int PAGE_CYC = PAGE_MAX_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // user requests
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_test,
  input wire logic [REQ_ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic [DATA_W-1:0] rdata,
  output logic rdata_valid,
  output logic init_done,
  // refresh configuration
  input wire logic refresh_enable,
  input wire logic refresh_cbr,
  input wire logic hidden_enable,
  // memory pins
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [ADDR_W-1:0] dram_addr,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [DATA_W-1:0] dq_in
);

  // ----------------------------------------------------------------
  // state and operation registers
  // ----------------------------------------------------------------
  ctrl_state_t state, next_state;
  logic [15:0] next_dur;
  logic state_done, idle_over, page_over, ref_tick;
  logic ref_pending, ref_take, burst_take;
  logic [3:0] burst_left;
  logic op_write, op_test;
  logic [ADDR_W-1:0] op_row, op_col;
  logic [DATA_W-1:0] op_wdata;
  logic [REF_ROW_W-1:0] ref_row;

  wire [ADDR_W-1:0] req_row = req_addr[REQ_ADDR_W-1:ADDR_W];
  wire [ADDR_W-1:0] req_col = req_addr[ADDR_W-1:0];
  wire state_change = (next_state != state);
  wire wake_due = idle_over && init_done;
  wire idle_go = (state == ST_IDLE) && (burst_left == 4'h0) &&
                 !wake_due && !ref_pending && init_done;
  wire page_go = (state == ST_CAS) && state_done && !op_test &&
                 !page_over && !ref_pending && !req_test &&
                 (req_row == op_row);
  wire accept = req_valid && req_ready;
  wire load_burst = (state == ST_POWER_WAIT && state_done) ||
                    (state == ST_IDLE && burst_left == 4'h0 && wake_due);
  wire ras_start = state_change &&
                   (next_state == ST_ROW || next_state == ST_REF_RAS ||
                    next_state == ST_CBR_RAS || next_state == ST_HIDDEN_RAS);

  assign req_ready = idle_go || page_go;

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  cycle_timer #(.W(16)) u_state_timer (
    .clk(clk),
    .nrst(nrst),
    .load(state_change),
    .value(next_dur),
    .done(state_done)
  );

  // any row cycle restarts the idle watch
  cycle_timer #(.W(21)) u_idle_timer (
    .clk(clk),
    .nrst(nrst),
    .load(ras_start),
    .value(21'(IDLE_CYC)),
    .done(idle_over)
  );

  // margin leaves room for one more page access and close
  cycle_timer #(.W(16)) u_page_timer (
    .clk(clk),
    .nrst(nrst),
    .load(state_change && next_state == ST_ROW),
    .value(16'(PAGE_CYC - CP_CYC - CAS_PAGE_CYC - 2)),
    .done(page_over)
  );

  tick_divider #(.W(12), .PERIOD(12'(REF_CYC))) u_ref_tick (
    .clk(clk),
    .nrst(nrst),
    .enable(refresh_enable),
    .tick(ref_tick)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    ref_take = 1'b0;
    burst_take = 1'b0;
    case (state)
      ST_RESET: next_state = ST_POWER_WAIT;
      // pause before the first row cycle
      ST_POWER_WAIT: if (state_done) next_state = ST_IDLE;
      ST_IDLE: begin
        if (burst_left != 4'h0) begin
          // bursts are column before row, so they prime the test
          next_state = ST_CBR_CAS;
          burst_take = 1'b1;
        end else if (wake_due) begin
          next_state = ST_IDLE;
        end else if (ref_pending) begin
          ref_take = 1'b1;
          next_state = refresh_cbr ? ST_CBR_CAS : ST_REF_RAS;
        end else if (req_valid && init_done) begin
          // test cycle opens with column before row
          next_state = req_test ? ST_CBR_CAS : ST_ROW;
        end
      end
      ST_ROW: if (state_done) next_state = ST_COL_SETUP;
      ST_COL_SETUP: if (state_done) next_state = ST_CAS;
      ST_CAS: begin
        if (state_done) begin
          if (page_go && req_valid) begin
            next_state = ST_CAS_PRE;
          end else if (ref_pending && hidden_enable) begin
            // keep column low, cycle the row strobe
            ref_take = 1'b1;
            next_state = ST_HIDDEN_UP;
          end else begin
            next_state = ST_RAS_PRE;
          end
        end
      end
      ST_CAS_PRE: if (state_done) next_state = ST_CAS;
      ST_HIDDEN_UP: if (state_done) next_state = ST_HIDDEN_RAS;
      ST_HIDDEN_RAS: if (state_done) next_state = ST_RAS_PRE;
      ST_REF_RAS: if (state_done) next_state = ST_RAS_PRE;
      ST_CBR_CAS: if (state_done) next_state = ST_CBR_RAS;
      ST_CBR_RAS: begin
        if (state_done) next_state = op_test ? ST_TEST_CPT : ST_RAS_PRE;
      end
      ST_TEST_CPT: if (state_done) next_state = ST_CAS;
      ST_RAS_PRE: if (state_done) next_state = ST_IDLE;
      default: next_state = ST_RESET;
    endcase
  end

  always_comb begin
    case (next_state)
      ST_POWER_WAIT: next_dur = 16'(PWR_WAIT_CYC);
      ST_ROW: next_dur = 16'(RAH_CYC);
      ST_COL_SETUP: next_dur = 16'(COL_SETUP_CYC);
      ST_CAS: next_dur = (state == ST_CAS_PRE) ? 16'(CAS_PAGE_CYC) :
                                                 16'(CAS_FIRST_CYC);
      ST_CAS_PRE: next_dur = 16'(CP_CYC);
      ST_RAS_PRE, ST_HIDDEN_UP: next_dur = 16'(RP_CYC);
      ST_REF_RAS, ST_HIDDEN_RAS: next_dur = 16'(RAS_CYC);
      ST_CBR_CAS: next_dur = 16'(CSR_CYC);
      ST_CBR_RAS: next_dur = op_test ? 16'(CHR_CYC) : 16'(RAS_CYC);
      ST_TEST_CPT: next_dur = 16'(CPT_CYC);
      default: next_dur = 16'h0001;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= ST_RESET;
      burst_left <= 4'h0;
      init_done <= 1'b0;
      ref_pending <= 1'b0;
      ref_row <= '0;
    end else begin
      state <= next_state;
      if (load_burst) burst_left <= 4'(INIT_BURST);
      else if (burst_take) burst_left <= burst_left - 4'h1;
      if (state == ST_IDLE && burst_left == 4'h0) init_done <= 1'b1;
      // a new tick wins over the take
      ref_pending <= ref_tick || (ref_pending && !ref_take);
      // own row counter, wraps over all rows
      if (state_change && next_state == ST_REF_RAS) ref_row <= ref_row + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      op_write <= 1'b0;
      op_test <= 1'b0;
      op_row <= '0;
      op_col <= '0;
      op_wdata <= '0;
    end else if (accept) begin
      op_write <= req_write;
      op_test <= req_test;
      op_row <= req_row;
      op_col <= req_col;
      op_wdata <= req_wdata;
    end else if (state == ST_IDLE) begin
      op_test <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pins, registered one cycle behind the state, except the row lines, which are registered with it
  // ----------------------------------------------------------------
  // strobes are low while active
  wire ras_low = (state == ST_ROW) || (state == ST_COL_SETUP) ||
                 (state == ST_CAS) || (state == ST_CAS_PRE) ||
                 (state == ST_REF_RAS) || (state == ST_CBR_RAS) ||
                 (state == ST_HIDDEN_RAS) || (state == ST_TEST_CPT);
  wire cas_low = (state == ST_CAS) || (state == ST_CBR_CAS) ||
                 (state == ST_CBR_RAS) || (state == ST_HIDDEN_UP) ||
                 (state == ST_HIDDEN_RAS);
  wire col_phase = (state == ST_COL_SETUP) || (state == ST_CAS) ||
                   (state == ST_CAS_PRE) || (state == ST_TEST_CPT);
  // write strobe leads the column fall, data driven meanwhile
  wire wr_phase = col_phase && op_write;
  // row field first, column field from the column phase on
  // row lines settle one cycle ahead of the row strobe fall
  wire [ADDR_W-1:0] next_dram_addr =
    (state_change && next_state == ST_ROW) ? req_row :
    (state_change && next_state == ST_REF_RAS) ?
      {1'b0, ref_row + 1'b1} :
    (state == ST_ROW) ? op_row :
    col_phase ? op_col :
    (state == ST_REF_RAS) ? {1'b0, ref_row} : dram_addr;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ras_n <= 1'b1;
      cas_n <= 1'b1;
      we_n <= 1'b1;
      dram_addr <= '0;
      dq_out <= '0;
      dq_oe_n <= 1'b1;
    end else begin
      ras_n <= !ras_low;
      cas_n <= !cas_low;
      we_n <= !wr_phase;
      dram_addr <= next_dram_addr;
      dq_out <= op_wdata;
      dq_oe_n <= !wr_phase;
    end
  end

  // sample while the column strobe is still low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= '0;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= (state == ST_CAS) && state_done && !op_write;
      if ((state == ST_CAS) && state_done && !op_write) rdata <= dq_in;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int REF_WAIT_BOUND = 300;
  logic [15:0] ras_lo_cnt, ras_hi_cnt, cas_lo_cnt, cas_hi_cnt, up_cnt;
  logic [3:0] fall_cnt;
  logic [8:0] ref_wait;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ras_lo_cnt <= 16'h0000;
      ras_hi_cnt <= 16'h0000;
      cas_lo_cnt <= 16'h0000;
      cas_hi_cnt <= 16'h0000;
      up_cnt <= 16'h0000;
      fall_cnt <= 4'h0;
      ref_wait <= 9'h000;
    end else begin
      ras_lo_cnt <= ras_n ? 16'h0000 : ras_lo_cnt + {15'h0000, ~&ras_lo_cnt};
      ras_hi_cnt <= !ras_n ? 16'h0000 : ras_hi_cnt + {15'h0000, ~&ras_hi_cnt};
      cas_lo_cnt <= cas_n ? 16'h0000 : cas_lo_cnt + {15'h0000, ~&cas_lo_cnt};
      cas_hi_cnt <= !cas_n ? 16'h0000 : cas_hi_cnt + {15'h0000, ~&cas_hi_cnt};
      up_cnt <= up_cnt + {15'h0000, ~&up_cnt};
      if (ras_low && ras_n && !(&fall_cnt)) fall_cnt <= fall_cnt + 4'h1;
      ref_wait <= (ref_pending && init_done) ?
                  ref_wait + {8'h00, ~&ref_wait} : 9'h000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence hidden_begin;
    $rose(ras_n) && !cas_n;
  endsequence
  sequence hidden_high;
    (ras_n && !cas_n) [*8];
  endsequence

  a_power_wait: assert property (
    $fell(ras_n) |-> up_cnt >= PWR_WAIT_CYC)
    else $error("row strobe fell before the power-up pause");
  a_init_burst: assert property (
    req_ready |-> fall_cnt >= 4'(INIT_BURST) && init_done)
    else $error("access offered before the initial row cycles");
  a_wake_gate: assert property (
    accept |-> !idle_over)
    else $error("access taken while the wake burst is owed");
  a_row_to_col: assert property (
    $fell(cas_n) && !ras_n && cas_hi_cnt > ras_lo_cnt |->
      ras_lo_cnt >= RCD_CYC && ras_lo_cnt <= RCD_MAX_CYC)
    else $error("first column fall outside row-to-column window");
  a_read_setup: assert property (
    $fell(cas_n) && we_n && !ras_n |-> $past(we_n) && dq_oe_n)
    else $error("write strobe not high ahead of read column fall");
  a_ras_pulse: assert property (
    $rose(ras_n) |-> ras_lo_cnt >= RAS_CYC)
    else $error("row strobe pulse too short");
  a_ras_precharge: assert property (
    $fell(ras_n) |-> ras_hi_cnt >= RP_CYC)
    else $error("row precharge too short");
  a_early_write: assert property (
    $fell(cas_n) && !we_n |-> $past(!we_n) && !dq_oe_n ##1 !dq_oe_n)
    else $error("early write strobe or data late");
  a_write_lead: assert property (
    $rose(cas_n) && $past(!we_n) |-> $past(cas_lo_cnt) >= CWL_CYC - 1)
    else $error("column strobe rose before write lead time");
  a_page_precharge: assert property (
    $fell(cas_n) && !ras_n && cas_hi_cnt <= ras_lo_cnt |->
      cas_hi_cnt >= CP_CYC)
    else $error("column precharge too short in page mode");
  a_page_end: assert property (
    $rose(ras_n) |-> cas_n || state == ST_HIDDEN_UP)
    else $error("row strobe rose before the column strobe");
  a_page_max: assert property (
    !ras_n |-> ras_lo_cnt <= PAGE_CYC)
    else $error("row strobe held low beyond page maximum");
  a_refresh_due: assert property (
    ref_pending |-> ref_wait < REF_WAIT_BOUND)
    else $error("refresh left pending too long");
  a_row_only: assert property (
    $fell(ras_n) && state == ST_REF_RAS |->
      cas_n && dram_addr == {1'b0, ref_row})
    else $error("row-only refresh without own row");
  a_cbr_order: assert property (
    $fell(ras_n) && !cas_n |-> cas_lo_cnt >= CSR_CYC)
    else $error("column before row setup too short");
  a_hidden_hold: assert property (
    hidden_begin |-> hidden_high)
    else $error("column strobe released during hidden refresh");

endmodule // dram_host

`default_nettype wire

// File: hw/dram_ctrl_pkg.sv
`default_nettype none

package dram_ctrl_pkg;

  // ----------------------------------------------------------------
  // clock and conversion helpers
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;

  // least time: round up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // longest time: round down, never below one cycle
  function automatic int cyc_dn(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 9;
  localparam int REQ_ADDR_W = 20;
  localparam int REF_ROW_W = 9;
  localparam int ROW_COUNT = 512;
  localparam int INIT_BURST = 8;

  // ----------------------------------------------------------------
  // pin timing, in ns
  // ----------------------------------------------------------------
  localparam int ROW_TO_COLUMN_DELAY_MIN_NS = 20;
  localparam int ROW_TO_COLUMN_DELAY_MAX_NS = 50;
  localparam int ROW_PULSE_WIDTH_NS = 70;
  localparam int COLUMN_PULSE_WIDTH_NS = 20;
  localparam int COLUMN_ACCESS_NS = 20;
  localparam int ROW_ACCESS_NS = 70;
  localparam int ROW_PRECHARGE_NS = 50;
  localparam int ROW_ADDRESS_HOLD_NS = 10;
  localparam int COLUMN_PRECHARGE_NS = 10;
  localparam int WRITE_LEAD_COLUMN_NS = 20;
  localparam int WRITE_LEAD_ROW_NS = 20;
  localparam int READ_SETUP_NS = 0;
  localparam int READ_HOLD_AFTER_COLUMN_NS = 0;
  localparam int CBR_SETUP_NS = 10;
  localparam int CBR_HOLD_NS = 30;
  localparam int TEST_COLUMN_PRECHARGE_NS = 40;
  localparam int PAGE_ROW_PULSE_MAX_NS = 100000;

  // ----------------------------------------------------------------
  // long intervals
  // ----------------------------------------------------------------
  localparam int POWER_WAIT_US = 200;
  localparam int IDLE_LIMIT_MS = 8;
  localparam int RETENTION_MS = 8;
  localparam real REFRESH_INTERVAL_US = 15.6;

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  localparam int RCD_CYC = cyc_up(ROW_TO_COLUMN_DELAY_MIN_NS);
  localparam int RCD_MAX_CYC = cyc_dn(ROW_TO_COLUMN_DELAY_MAX_NS);
  localparam int RAS_CYC = cyc_up(ROW_PULSE_WIDTH_NS);
  localparam int CAS_CYC = cyc_up(COLUMN_PULSE_WIDTH_NS);
  localparam int CAC_CYC = cyc_up(COLUMN_ACCESS_NS);
  localparam int RAC_CYC = cyc_up(ROW_ACCESS_NS);
  localparam int RP_CYC = cyc_up(ROW_PRECHARGE_NS);
  localparam int RAH_CYC = cyc_up(ROW_ADDRESS_HOLD_NS);
  localparam int CP_CYC = cyc_up(COLUMN_PRECHARGE_NS);
  localparam int CWL_CYC = cyc_up(WRITE_LEAD_COLUMN_NS);
  localparam int RWL_CYC = cyc_up(WRITE_LEAD_ROW_NS);
  localparam int RCS_CYC = cyc_up(READ_SETUP_NS);
  localparam int CSR_CYC = cyc_up(CBR_SETUP_NS);
  localparam int CHR_CYC = cyc_up(CBR_HOLD_NS);
  localparam int CPT_CYC = cyc_up(TEST_COLUMN_PRECHARGE_NS);
  localparam int COL_SETUP_CYC = imax(RCS_CYC, RCD_CYC - RAH_CYC);
  // one extra cycle so the sample edge lands after the access time
  localparam int CAS_PAGE_CYC =
    imax(imax(CAS_CYC, CAC_CYC + 1), imax(CWL_CYC, RWL_CYC));
  localparam int CAS_FIRST_CYC = imax(CAS_PAGE_CYC,
    imax(RAS_CYC - RCD_CYC, RAC_CYC + 1 - RCD_CYC));
  localparam int REF_CYC = int'(REFRESH_INTERVAL_US * CLK_MHZ);
  localparam int POWER_WAIT_CYC = POWER_WAIT_US * CLK_MHZ;
  localparam int IDLE_LIMIT_CYC = IDLE_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int PAGE_MAX_CYC = cyc_dn(PAGE_ROW_PULSE_MAX_NS);

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_POWER_WAIT = 4'h1,
    ST_IDLE       = 4'h2,
    ST_ROW        = 4'h3,
    ST_COL_SETUP  = 4'h4,
    ST_CAS        = 4'h5,
    ST_CAS_PRE    = 4'h6,
    ST_RAS_PRE    = 4'h7,
    ST_REF_RAS    = 4'h8,
    ST_CBR_CAS    = 4'h9,
    ST_CBR_RAS    = 4'hA,
    ST_HIDDEN_UP  = 4'hB,
    ST_HIDDEN_RAS = 4'hC,
    ST_TEST_CPT   = 4'hD
  } ctrl_state_t;

endpackage

`default_nettype wire

// File: hw/cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none

// load starts a span of value cycles; done is high in its last cycle
module cycle_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);

  logic [W-1:0] count;

  assign done = (count == '0);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count <= '0;
    end else if (load) begin
      count <= value - 1'b1;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

endmodule // cycle_timer

`default_nettype wire

// File: hw/tick_divider.sv
`timescale 1ns/1ps
`default_nettype none

// one-cycle tick every PERIOD cycles while enabled
module tick_divider #(
  parameter int W = 12,
  parameter logic [W-1:0] PERIOD = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic enable,
  output logic tick
);

  logic [W-1:0] count;
  wire at_end = (count == PERIOD - 1'b1);

  assign tick = enable && at_end;

  always_ff @(posedge clk) begin
    if (!nrst || !enable || at_end) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule // tick_divider

`default_nettype wire

// File: verification/dram_model.sv
`timescale 1ns/1ps
`default_nettype none

module dram_model
  import dram_ctrl_pkg::*;
(
  // strobes and address
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] dram_addr,
  // data
  input wire logic [DATA_W-1:0] dq_out,
  output logic [DATA_W-1:0] dq_in,
  // activity counts
  output int n_cbr,
  output int n_rows,
  output int n_ras_only
);
  logic [DATA_W-1:0] mem [int];
  logic [ADDR_W-1:0] row;
  logic [DATA_W-1:0] rd;
  logic rd_on, col_seen, cbr;
  logic [REF_ROW_W-1:0] ctr;
  initial begin
    n_cbr = 0;
    n_rows = 0;
    n_ras_only = 0;
    {rd_on, col_seen, cbr, rd, row, ctr} = '0;
  end
  // unlatched output
  // released lines show the inverse so a stale value never passes
  assign dq_in = rd_on ? rd : ~rd;
  always @(negedge ras_n) begin
    cbr = !cas_n;
    col_seen = 0;
    // internal counter names the row, address ignored
    if (cbr) begin
      n_cbr++;
      row = {1'b0, ctr};
      ctr++;
    end else begin
      // any row opened is refreshed as a whole
      row = dram_addr;
      n_rows++;
    end
  end
  // column only counts once the row strobe is low
  always @(negedge cas_n) if (!ras_n) begin
    col_seen = 1;
    if (!we_n) mem[{row, dram_addr}] = dq_out;
    else begin
      rd = mem.exists({row, dram_addr}) ? mem[{row, dram_addr}] : '0;
      rd_on = 1;
    end
  end
  always @(posedge cas_n) rd_on = 0;
  always @(posedge ras_n) if (!cbr && !col_seen) n_ras_only++;
endmodule // dram_model

`default_nettype wire

// File: verification/tb_dram_host.sv
`timescale 1ns/1ps
`default_nettype none

module tb_dram_host;
  import dram_ctrl_pkg::*;
  logic clk, nrst, req_valid, req_ready, req_write, req_test;
  logic [REQ_ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, rdata, dq_out, dq_in;
  logic rdata_valid, init_done, refresh_enable, refresh_cbr;
  logic hidden_enable, ras_n, cas_n, we_n, dq_oe_n;
  logic [ADDR_W-1:0] dram_addr;
  int n_cbr, n_rows, n_ras_only, n_fail, n_checks, c0;

  // idle limit above the refresh period, so refresh keeps the part awake
  dram_host #(.PWR_WAIT_CYC(50), .IDLE_CYC(4000), .PAGE_CYC(60)) u_dut (
    .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_test(req_test), .req_addr(req_addr),
    .req_wdata(req_wdata), .rdata(rdata), .rdata_valid(rdata_valid),
    .init_done(init_done), .refresh_enable(refresh_enable),
    .refresh_cbr(refresh_cbr), .hidden_enable(hidden_enable),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .dram_addr(dram_addr),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
  dram_model u_mem (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .dram_addr(dram_addr), .dq_out(dq_out), .dq_in(dq_in), .n_cbr(n_cbr),
    .n_rows(n_rows), .n_ras_only(n_ras_only));

  task automatic chk_data(input logic [DATA_W-1:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, exp);
    n_checks++;
    if (got != exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // request driving
  // ----------------------------------------------------------------
  task automatic op(input logic w, input logic [19:0] a,
                    input logic [8:0] d);
    int k;
    @(negedge clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    for (k = 0; k < 8000 && req_ready !== 1'b1; k++) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    req_valid = 0;
  endtask
  task automatic rd_chk(input logic [19:0] a, input logic [8:0] exp);
    int k;
    op(1'b0, a, 9'h000);
    for (k = 0; k < 40 && rdata_valid !== 1'b1; k++) @(negedge clk);
    chk_data(rdata, exp);
  endtask
  task automatic test_done;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #(30000 * 5);
    n_fail++;
    test_done;
  end
  initial begin
    {nrst, req_valid, req_write, req_test, req_addr, req_wdata} = '0;
    {refresh_enable, refresh_cbr, hidden_enable, n_fail, n_checks} = '0;
    repeat (12) @(negedge clk);
    nrst = 1;
    for (c0 = 0; c0 < 2000 && init_done !== 1'b1; c0++) @(negedge clk);
    chk_cnt(n_cbr, INIT_BURST);
    $display("init done");
    op(1'b1, 20'h003FF, 9'h1FF);
    op(1'b1, 20'hFFC00, 9'h0A5);
    rd_chk(20'h003FF, 9'h1FF);
    rd_chk(20'hFFC00, 9'h0A5);
    $display("read write done");
    c0 = n_rows;
    op(1'b1, 20'h55001, 9'h101);
    op(1'b1, 20'h55002, 9'h102);
    op(1'b1, 20'h55003, 9'h103);
    repeat (30) @(negedge clk);
    chk_cnt(n_rows - c0, 1);
    rd_chk(20'h55002, 9'h102);
    $display("page done");
    refresh_enable = 1;
    c0 = n_ras_only;
    repeat (3200) @(negedge clk);
    chk_cnt(n_ras_only - c0, 1);
    refresh_cbr = 1;
    c0 = n_cbr;
    repeat (3120) @(negedge clk);
    chk_cnt(n_cbr - c0, 1);
    rd_chk(20'h55003, 9'h103);
    $display("refresh done");
    test_done;
  end
endmodule // tb_dram_host

`default_nettype wire
